// File: fgc_amp_decode.sv
`timescale 1ns/100ps
`default_nettype none
module fgc_amp_decode
   import fgc_pkg::*;
(
   input  wire logic [15:0] amp_reg_i,
   output fgc_amp_cfg_t     cfg_o
);
   wire logic [2:0] lpf_w = amp_reg_i[3:1];

   assign cfg_o.lowpass_corner_select = lpf_w;  // [R1]
   assign cfg_o.lpf_code_valid = (lpf_w == FGC_LPF_15) || (lpf_w == FGC_LPF_20) ||
                                 (lpf_w == FGC_LPF_30) || (lpf_w == FGC_LPF_10);  // [R1]
   assign cfg_o.amp_offset_loop_off = amp_reg_i[4];  // [R2]
   // -4 dBFS code falls back to default -2 dBFS when clamp disabled
   assign cfg_o.amp_clamp_threshold =
      (amp_reg_i[6:5] == 2'h1 && amp_reg_i[7]) ? 2'h0 : amp_reg_i[6:5];  // [R3]
   assign cfg_o.amp_clamp_on  = !amp_reg_i[7];  // [R4]
   assign cfg_o.amp_gain_30db = amp_reg_i[13];  // [R18]
endmodule : fgc_amp_decode
`default_nettype wire

// File: fgc_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module fgc_config_regs
   import fgc_pkg::*;
#(
   parameter int unsigned NUM_CH = 8
)(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire fgc_wr_t           wr_i,
   input  wire logic [7:0]        rd_addr_i,
   output logic      [15:0]       rd_data_o,
   output logic                   rd_hit_o,
   output fgc_amp_cfg_t           amp_cfg_o,
   output fgc_term_cfg_t          term_cfg_o,
   output logic      [NUM_CH-1:0] channel_sleep_mask_o,
   output fgc_pmode_t             power_mode_o
);
   logic [15:0] amp_q;
   logic [15:0] amp_d;
   logic [15:0] term_q;
   logic [15:0] term_d;
   logic [15:0] pwr_q;
   logic [15:0] pwr_d;
   fgc_amp_cfg_t  amp_cfg_q;
   fgc_amp_cfg_t  amp_cfg_w;
   fgc_term_cfg_t term_cfg_q;
   fgc_term_cfg_t term_cfg_w;
   logic [NUM_CH-1:0] sleep_q;
   fgc_pmode_t        pmode_q;
   fgc_pmode_t        pmode_w;

   wire logic wr_amp_w  = wr_i.we && (wr_i.addr == FGC_ADDR_AMP);
   wire logic wr_term_w = wr_i.we && (wr_i.addr == FGC_ADDR_TERM);
   wire logic wr_pwr_w  = wr_i.we && (wr_i.addr == FGC_ADDR_POWER);

   // reserved bits forced to zero so stray host writes have no effect
   assign amp_d  = wr_amp_w  ? (wr_i.wdata & FGC_MASK_AMP)   : amp_q;  // [R19]
   assign term_d = wr_term_w ? (wr_i.wdata & FGC_MASK_TERM)  : term_q;  // [R19]
   assign pwr_d  = wr_pwr_w  ? (wr_i.wdata & FGC_MASK_POWER) : pwr_q;  // [R19]

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         amp_q  <= FGC_RESET_VAL;  // [R19]
         term_q <= FGC_RESET_VAL;
         pwr_q  <= FGC_RESET_VAL;
      end else begin
         amp_q  <= amp_d;
         term_q <= term_d;
         pwr_q  <= pwr_d;
      end
   end

   fgc_amp_decode u_amp (
      .amp_reg_i (amp_q),
      .cfg_o     (amp_cfg_w)
   );

   fgc_term_decode u_term (
      .term_reg_i (term_q),
      .cfg_o      (term_cfg_w)
   );

   // both mode bits set is not a defined mode; flagged rather than guessed
   assign pmode_w = (pwr_q[10] && !pwr_q[11]) ? FGC_PM_LOW :  // [R15]
                    (pwr_q[11] && !pwr_q[10]) ? FGC_PM_MEDIUM :  // [R16]
                    (pwr_q[11] &&  pwr_q[10]) ? FGC_PM_INVALID : FGC_PM_LOW_NOISE;

   // outputs registered so analog controls never see decode glitches
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         amp_cfg_q  <= '0;
         term_cfg_q <= '0;
         sleep_q    <= '0;
         pmode_q    <= FGC_PM_LOW_NOISE;
      end else begin
         amp_cfg_q  <= amp_cfg_w;
         term_cfg_q <= term_cfg_w;
         sleep_q    <= pwr_q[NUM_CH-1:0];  // [R14]
         pmode_q    <= pmode_w;
      end
   end

   assign amp_cfg_o            = amp_cfg_q;
   assign term_cfg_o           = term_cfg_q;
   assign channel_sleep_mask_o = sleep_q;
   assign power_mode_o         = pmode_q;

   assign rd_hit_o  = (rd_addr_i == FGC_ADDR_AMP) || (rd_addr_i == FGC_ADDR_TERM) ||
                      (rd_addr_i == FGC_ADDR_POWER);
   assign rd_data_o = (rd_addr_i == FGC_ADDR_AMP)   ? amp_q :
                      (rd_addr_i == FGC_ADDR_TERM)  ? term_q :
                      (rd_addr_i == FGC_ADDR_POWER) ? pwr_q : 16'h0000;
endmodule : fgc_config_regs
`default_nettype wire

// File: fgc_config_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module fgc_regs_chk
   import fgc_pkg::*;
#(parameter int unsigned NUM_CH = 8)(
   input wire logic              clk_i,
   input wire logic              rst_n_i,
   input wire fgc_wr_t           wr_i,
   input wire logic [7:0]        rd_addr_i,
   input wire logic [15:0]       rd_data_o,
   input wire logic              rd_hit_o,
   input wire fgc_amp_cfg_t      amp_cfg_o,
   input wire fgc_term_cfg_t     term_cfg_o,
   input wire logic [NUM_CH-1:0] channel_sleep_mask_o,
   input wire fgc_pmode_t        power_mode_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire logic wa = wr_i.we && wr_i.addr == FGC_ADDR_AMP;
   wire logic wt = wr_i.we && wr_i.addr == FGC_ADDR_TERM;
   wire logic wp = wr_i.we && wr_i.addr == FGC_ADDR_POWER;
   a_sleep_map: assert property (wp ##1 !wp
      |=> channel_sleep_mask_o == $past(wr_i.wdata[7:0], 2)) else $error("sleep mask");
   a_power_mode: assert property (wp ##1 !wp
      |=> power_mode_o == 4'h1 << $past(wr_i.wdata[11:10], 2)) else $error("power mode");
   a_term_on: assert property (wt ##1 !wt
      |=> term_cfg_o.term_on == $past(wr_i.wdata[8], 2)) else $error("term enable");
   a_amp_gain: assert property (wa ##1 !wa
      |=> amp_cfg_o.amp_gain_30db == $past(wr_i.wdata[13], 2)) else $error("amp gain");
   a_lpf_code: assert property (wa ##1 !wa
      |=> amp_cfg_o.lowpass_corner_select == $past(wr_i.wdata[3:1], 2)) else $error("lpf");
   a_clamp_on: assert property (wa ##1 !wa
      |=> amp_cfg_o.amp_clamp_on != $past(wr_i.wdata[7], 2)) else $error("clamp");
   a_read_hit: assert property (rd_hit_o == (rd_addr_i inside {[8'h33:8'h35]}))
      else $error("read hit");
   a_cfg_hold: assert property (!wr_i.we [*3] |-> $stable(term_cfg_o) && $stable(amp_cfg_o))
      else $error("config moved");
   a_high_z: assert property (wt ##1 !wt
      |=> term_cfg_o.high_z == ($past(wr_i.wdata[14:13], 2) == 2'h2 &&
                                $past(wr_i.wdata[7:5], 2) == 3'h0)) else $error("high z");
endmodule : fgc_regs_chk
bind fgc_config_regs fgc_regs_chk #(.NUM_CH(NUM_CH)) fgc_regs_chk_inst (
   .clk_i                (clk_i),
   .rst_n_i              (rst_n_i),
   .wr_i                 (wr_i),
   .rd_addr_i            (rd_addr_i),
   .rd_data_o            (rd_data_o),
   .rd_hit_o             (rd_hit_o),
   .amp_cfg_o            (amp_cfg_o),
   .term_cfg_o           (term_cfg_o),
   .channel_sleep_mask_o (channel_sleep_mask_o),
   .power_mode_o         (power_mode_o)
);
`default_nettype wire

// File: fgc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fgc_host_model
   import fgc_pkg::*;
(
   input  wire logic clk_i,
   output var fgc_wr_t wr_o
);
   initial wr_o = '0;
   // idle lines carry the inverse of the last word so nothing stale looks valid
   task automatic write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      #1 wr_o = '{1'b1, a, d};
      @(posedge clk_i);
      #1 wr_o = '{1'b0, ~a, ~d};
   endtask : write
endmodule : fgc_host_model
`default_nettype wire

// File: fgc_pkg.sv
// Summary of operation
// [R1] lowpass corner code 000=15, 010=20, 011=30, 100=10 MHz
// [R2] amplifier offset integrator off while its disable bit is 1
// [R3] clamp level 00=-2, 10=0, 01=-4 dBFS, last only while clamp enabled
// [R4] amplifier current clamp enabled while clamp-disable bit is 0
// [R5] per-resistor termination field acts only while individual enable is 1
// [R6] individual enable 1 routes per-resistor field to resistor selection
// [R7] termination preset 00/01/10/11 = 50/100/200/400 ohm, resistors auto-mapped
// [R8] at 12 dB input gain, preset 00 gives high impedance
// [R9] active termination enabled only while its enable bit is 1
// [R10] input clamp 00 auto, 01 1.5, 10 1.15, 11 0.6 Vpp
// [R11] input amplifier offset integrator off while its disable bit is 1
// [R12] input gain 00=18, 01=24, 10=12 dB; 11 reserved
// [R13] per-channel gain enable takes gain from per-channel register
// [R14] channel sleep bit n powers down channel n+1
// [R15] low-power bit selects low power mode only while mid-power bit is 0
// [R16] mid-power bit selects medium power only while low-power bit is 0
// [R17] host sets per-channel gain enable for per-channel gains to act
// [R18] amplifier gain select 0 gives 24 dB, 1 gives 30 dB
// [R19] host writes reserved bits as zero; all fields reset to zero
package fgc_pkg;
   localparam logic [7:0]  FGC_ADDR_AMP   = 8'h33;
   localparam logic [7:0]  FGC_ADDR_TERM  = 8'h34;
   localparam logic [7:0]  FGC_ADDR_POWER = 8'h35;
   localparam logic [15:0] FGC_RESET_VAL  = 16'h0000;
   // writable bit masks: reserved bits held at zero
   localparam logic [15:0] FGC_MASK_AMP   = 16'h20fe;
   localparam logic [15:0] FGC_MASK_TERM  = 16'hf7ff;
   localparam logic [15:0] FGC_MASK_POWER = 16'h0cff;

   typedef enum logic [2:0] {
      FGC_LPF_15 = 3'h0,
      FGC_LPF_20 = 3'h2,
      FGC_LPF_30 = 3'h3,
      FGC_LPF_10 = 3'h4
   } fgc_lpf_t;

   typedef enum logic [1:0] {
      FGC_IG_18 = 2'h0,
      FGC_IG_24 = 2'h1,
      FGC_IG_12 = 2'h2,
      FGC_IG_RSV = 2'h3
   } fgc_igain_t;

   typedef enum logic [3:0] {
      FGC_PM_LOW_NOISE = 4'h1,
      FGC_PM_LOW       = 4'h2,
      FGC_PM_MEDIUM    = 4'h4,
      FGC_PM_INVALID   = 4'h8
   } fgc_pmode_t;

   typedef struct packed {
      logic        we;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } fgc_wr_t;

   typedef struct packed {
      logic [2:0] lowpass_corner_select;
      logic       lpf_code_valid;
      logic       amp_offset_loop_off;
      logic [1:0] amp_clamp_threshold;
      logic       amp_clamp_on;
      logic       amp_gain_30db;
   } fgc_amp_cfg_t;

   typedef struct packed {
      logic [4:0] resistor_sel;
      logic       term_on;
      logic       high_z;
      logic [1:0] input_clamp_select;
      logic       input_offset_loop_off;
      logic [1:0] input_amp_gain;
      logic       per_channel_gain_on;
   } fgc_term_cfg_t;
endpackage : fgc_pkg

// File: fgc_term_decode.sv
`timescale 1ns/100ps
`default_nettype none
module fgc_term_decode
   import fgc_pkg::*;
(
   input  wire logic [15:0] term_reg_i,
   output fgc_term_cfg_t    cfg_o
);
   wire logic [4:0] indiv_w   = term_reg_i[4:0];
   wire logic       indiv_en_w = term_reg_i[5];
   wire logic [1:0] preset_w  = term_reg_i[7:6];
   wire logic [1:0] gain_w    = term_reg_i[14:13];

   // preset resistor maps: 50/100/200/400 ohm per gain, except preset 00 at 12 dB selects no resistor (high impedance)
   function automatic logic [4:0] preset_map(input logic [1:0] p, input logic [1:0] g);
      logic [4:0] r;
      r = 5'h00;
      unique case (g)
         FGC_IG_24: r = (p == 2'h0) ? 5'h01 : (p == 2'h1) ? 5'h02 : (p == 2'h2) ? 5'h04 : 5'h08;
         FGC_IG_12: r = (p == 2'h0) ? 5'h00 : (p == 2'h1) ? 5'h03 : (p == 2'h2) ? 5'h06 : 5'h0c;
         default:   r = (p == 2'h0) ? 5'h07 : (p == 2'h1) ? 5'h06 : (p == 2'h2) ? 5'h03 : 5'h0a;
      endcase
      return r;
   endfunction : preset_map

   wire logic high_z_w = (gain_w == FGC_IG_12) && (preset_w == 2'h0) && !indiv_en_w;  // [R8]

   assign cfg_o.resistor_sel = indiv_en_w ? indiv_w : preset_map(preset_w, gain_w);  // [R5] [R6] [R7]
   assign cfg_o.term_on      = term_reg_i[8];  // [R9]
   assign cfg_o.high_z       = high_z_w;
   assign cfg_o.input_clamp_select    = term_reg_i[10:9];  // [R10]
   assign cfg_o.input_offset_loop_off = term_reg_i[12];  // [R11]
   assign cfg_o.input_amp_gain        = gain_w;  // [R12]
   assign cfg_o.per_channel_gain_on   = term_reg_i[15];  // [R13]
endmodule : fgc_term_decode
`default_nettype wire

// File: tb_fgc_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fgc_config_regs
   import fgc_pkg::*;
;
   logic          clk_i = 0;
   logic          rst_n_i = 0;
   logic [7:0]    ra = 8'h00;
   fgc_wr_t       wr;
   logic [15:0]   rd;
   logic          hit;
   fgc_amp_cfg_t  amp;
   fgc_term_cfg_t term;
   logic [7:0]    slp;
   fgc_pmode_t    pm;
   logic [15:0]   sh [3] = '{default: 16'h0};
   int            num_errors = 0;
   int            total_checks = 0;
   always #10 clk_i = ~clk_i;
   fgc_host_model fgc_host_model_inst (.clk_i(clk_i), .wr_o(wr));
   fgc_config_regs #(.NUM_CH(8)) fgc_config_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .wr_i(wr), .rd_addr_i(ra), .rd_data_o(rd), .rd_hit_o(hit), .amp_cfg_o(amp),
      .term_cfg_o(term), .channel_sleep_mask_o(slp), .power_mode_o(pm));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic fgc_amp_cfg_t ea(input logic [15:0] w);
      return '{w[3:1], w[3:1] inside {3'h0, 3'h2, 3'h3, 3'h4}, w[4],
               (w[7] && w[6:5] == 2'h1) ? 2'h0 : w[6:5], !w[7], w[13]};
   endfunction : ea
   function automatic fgc_term_cfg_t et(input logic [15:0] w);
      logic [31:0] m;
      m = w[14] ? 32'h0c060300 : w[13] ? 32'h08040201 : 32'h0a030607;
      return '{w[5] ? w[4:0] : m[8*w[7:6] +: 5], w[8], !w[5] && w[14:13] == 2'h2 && !w[7:6],
               w[10:9], w[12], w[14:13], w[15]};
   endfunction : et
   task automatic check_all();
      for (int i = 0; i < 4; i++) begin
         ra = (i < 3) ? 8'h33 + 8'(i) : 8'h36 + 8'($urandom_range(0, 200));
         #1;
         check(32'(rd), i < 3 ? 32'(sh[i]) : 32'h0);
         check(32'(hit), 32'(i < 3));
      end
      check(32'(amp), 32'(ea(sh[0])));
      check(32'(term), 32'(et(sh[1])));
      check(32'(slp), 32'(sh[2][7:0]));
      check(32'(pm), 32'h1 << sh[2][11:10]);
   endtask : check_all
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   initial begin
      logic [7:0]  a;
      logic [15:0] d;
      void'($urandom(85));
      repeat (6) @(posedge clk_i);
      #1 rst_n_i = 1;
      @(posedge clk_i);
      #1 check_all();
      for (int n = 0; n < 312; n++) begin
         a = n < 12 ? 8'h34 : 8'h33 + 8'($urandom_range(0, 3));
         d = n < 12 ? 16'h0100 | 16'(n % 4) << 6 | 16'(n / 4) << 13 : 16'($urandom);
         if (d[14:13] == 2'h3) d[14] = 1'b0; // reserved gain never sent
         fgc_host_model_inst.write(a, d);
         if (a < 8'h36) sh[a - 8'h33] = d & (a == 8'h33 ? FGC_MASK_AMP :
            a == 8'h34 ? FGC_MASK_TERM : FGC_MASK_POWER);
         @(posedge clk_i);
         #1 check_all();
      end
      @(posedge clk_i);
      #1 rst_n_i = 0;
      sh = '{default: 16'h0};
      // reset is asynchronous: outputs must already be cleared in mid-cycle
      #1;
      check(32'(amp), 32'h0);
      check(32'(term), 32'h0);
      check(32'(slp), 32'h0);
      check(32'(pm), 32'h1);
      @(posedge clk_i);
      #1 rst_n_i = 1;
      @(posedge clk_i);
      #1 check_all();
      finish_test();
   end
endmodule : tb_fgc_config_regs
`default_nettype wire
